// ==== core/acdc_defines.svh ====
// register offsets, reset values, field positions and ratio constants
`ifndef ACDC_DEFINES_SVH
`define ACDC_DEFINES_SVH

`define ACDC_ADDR_PRIM_LOW  8'h3c
`define ACDC_ADDR_SEC_LOW   8'h3d
`define ACDC_ADDR_ANA       8'h3e
`define ACDC_ADDR_CORE_EN   8'h44
`define ACDC_ADDR_PORT_EN   8'h45

`define ACDC_RST_PRIM_LOW   8'h01
`define ACDC_RST_SEC_LOW    8'h01
`define ACDC_RST_ANA        6'h01
`define ACDC_RST_CORE_EN    3'h0
`define ACDC_RST_PORT_EN    8'h00
`define ACDC_RST_RDATA      8'h00
`define ACDC_READ_ZERO      8'h00

`define ACDC_BCLK_W         9
`define ACDC_ANA_W          6
`define ACDC_CORE_W         3
`define ACDC_RATIO_W        10
`define ACDC_BCLK_ZERO      10'h200
`define ACDC_ANA_ZERO       10'h040

`define ACDC_BIT_N          2
`define ACDC_BIT_M          1
`define ACDC_BIT_PDM        0
`define ACDC_BIT_ADC_DEM    7
`define ACDC_BIT_ADC_MOD    6
`define ACDC_BIT_DAC_DEM    5
`define ACDC_BIT_DAC_MOD    4
`define ACDC_BIT_PBCLK      3
`define ACDC_BIT_SBCLK      2
`define ACDC_BIT_PFRAME     1
`define ACDC_BIT_SFRAME     0

`endif

// ==== core/acdc_pkg.sv ====
// state types and ratio decode shared by the register block and the divider block
package acdc_pkg;

  typedef struct packed {
    logic [7:0] prim_low;
    logic [7:0] sec_low;
    logic [5:0] ana;
    logic [2:0] core_en;
    logic [7:0] port_en;
    logic [7:0] rdata;
    logic       rvalid;
  } acdc_regs_t;

  typedef struct packed {
    logic [9:0] cnt;
    logic [9:0] ratio;
    logic       clk;
    logic       tick;
  } acdc_div_state_t;

  // code zero stands for the largest ratio, any other code for itself
  function automatic logic [9:0] acdc_ratio(input logic [8:0] code,
                                            input logic [9:0] zero_ratio);
    if (code == 9'h000)
      return zero_ratio;
    else
      return {1'b0, code};
  endfunction

endpackage

// ==== core/acdc_div_if.sv ====
// control and output signals between the register block and one divider
`timescale 1ns/10ps
interface acdc_div_if #(parameter int W = 9);
  logic         on;
  logic         auto;
  logic [W-1:0] code;
  logic [W-1:0] auto_code;
  logic         clk_lvl;
  logic         tick;

  modport ctrl (output on, output auto, output code, output auto_code,
                input clk_lvl, input tick);
  modport div  (input on, input auto, input code, input auto_code,
                output clk_lvl, output tick);
endinterface

// ==== core/acdc_ratio_div.sv ====
// programmable ratio divider with end-of-period code update
`timescale 1ns/10ps
`include "acdc_defines.svh"
module acdc_ratio_div #(
  parameter int         W          = `ACDC_BCLK_W,
  parameter logic [9:0] ZERO_RATIO = `ACDC_BCLK_ZERO
) (
  input wire logic sys_clk,
  input wire logic rst_n,
  acdc_div_if.div  link
);

  acdc_pkg::acdc_div_state_t s_q;
  acdc_pkg::acdc_div_state_t s_d;
  logic [9:0]                ratio_next;
  logic [9:0]                half;
  logic [9:0]                cnt_inc;

  always_comb
  begin
    // auto mode takes the detected code and ignores the programmed one
    ratio_next = link.auto ? acdc_pkg::acdc_ratio(9'(link.auto_code), ZERO_RATIO)
                           : acdc_pkg::acdc_ratio(9'(link.code), ZERO_RATIO);
    half       = 10'((s_q.ratio + 10'h001) >> 1);
    cnt_inc    = 10'(s_q.cnt + 10'h001);
    s_d        = s_q;
    if (!link.on)
    begin
      // parked on the last count so enabling starts a clean high phase
      s_d.cnt   = 10'(ratio_next - 10'h001);
      s_d.ratio = ratio_next;
      s_d.clk   = 1'b0;
      s_d.tick  = 1'b0;
    end
    else if (s_q.cnt >= 10'(s_q.ratio - 10'h001))
    begin
      // new code only at a period boundary: no runt phases
      s_d.cnt   = 10'h000;
      s_d.ratio = ratio_next;
      s_d.clk   = 1'b1;
      s_d.tick  = 1'b1;
    end
    else
    begin
      s_d.cnt   = cnt_inc;
      s_d.clk   = (cnt_inc < half);
      s_d.tick  = 1'b0;
    end
  end

  always_ff @(posedge sys_clk or negedge rst_n)
  begin
    if (!rst_n)
      s_q <= '0;
    else
      s_q <= s_d;
  end

  assign link.clk_lvl = s_q.clk;
  assign link.tick    = s_q.tick;

endmodule

// ==== core/acdc_clock_divider_config.sv ====
// divider configuration registers and the bit clock and analog ratio dividers
// Operation
// RQ1: a read-write byte at 0x3c holds the primary bit clock divider low byte, reset one.
// RQ2: a bit clock code of zero divides by 512.
// RQ3: any other bit clock code divides by its own value, up to 511.
// RQ4: with auto detection on, bit clock dividers use the detected code, not the programmed one.
// RQ5: a read-write byte at 0x3d holds the secondary bit clock low byte, same coding, reset one.
// RQ6: the analog ratio field is bits 5..0 at 0x3e, top two bits reserved, reset one.
// RQ7: analog ratio code zero divides by 64, codes 1 to 63 divide by themselves.
// RQ8: with auto detection on, the programmed analog ratio is ignored.
// RQ9: reserved bits read zero and software writes them only with their reset values.
// RQ10: bit 2 at 0x44 switches the n divider on when one, reset zero.
// RQ11: bit 1 at 0x44 switches the m divider on when one, reset zero.
// RQ12: bit 0 at 0x44 switches the density modulation divider on when one, reset zero.
// RQ13: the register at 0x44 resets to zero with bits 7..3 reserved and 2..0 read-write.
// RQ14: the register at 0x45 holds eight read-write enables, reset zero, in the fixed order.
// RQ15: each bit at 0x45 enables its divider when one and disables it when zero.
// RQ16: each bit clock code is nine bits, its top bit joined above the low byte.
// RQ17: new codes take effect at the next period without glitches; an off divider holds low.
`timescale 1ns/10ps
`include "acdc_defines.svh"
module acdc_clock_divider_config (
  input  wire logic       sys_clk,
  input  wire logic       rst_b,
  input  wire logic       reg_wr,
  input  wire logic       reg_rd,
  input  wire logic [7:0] reg_addr,
  input  wire logic [7:0] reg_wdata,
  output logic      [7:0] reg_rdata,
  output logic            reg_rvalid,
  input  wire logic       auto_detect_on,
  input  wire logic       primary_bitclk_div_top,
  input  wire logic       secondary_bitclk_div_top,
  input  wire logic [8:0] auto_primary_code,
  input  wire logic [8:0] auto_secondary_code,
  input  wire logic [5:0] auto_analog_code,
  output logic            primary_bitclk_out,
  output logic            primary_bitclk_tick,
  output logic            secondary_bitclk_out,
  output logic            secondary_bitclk_tick,
  output logic            analog_ratio_clk,
  output logic            analog_ratio_tick,
  output logic            n_divider_on,
  output logic            m_divider_on,
  output logic            density_mod_divider_on,
  output logic            adc_element_match_div_on,
  output logic            adc_modulator_div_on,
  output logic            dac_element_match_div_on,
  output logic            dac_modulator_div_on,
  output logic            primary_bitclk_div_on,
  output logic            secondary_bitclk_div_on,
  output logic            primary_frame_div_on,
  output logic            secondary_frame_div_on
);

  logic [1:0]             rst_sync_q;
  logic                   rst_n;
  acdc_pkg::acdc_regs_t   r_q;
  acdc_pkg::acdc_regs_t   r_d;
  logic                   hit_prim;
  logic                   hit_sec;
  logic                   hit_ana;
  logic                   hit_core;
  logic                   hit_port;
  logic [7:0]             read_word;

  // reset: asserted at once, released through two flops
  always_ff @(posedge sys_clk or negedge rst_b)
  begin
    if (!rst_b)
      rst_sync_q <= 2'b00;
    else
      rst_sync_q <= {rst_sync_q[0], 1'b1};
  end

  assign rst_n = rst_sync_q[1];

  acdc_div_if #(.W(`ACDC_BCLK_W)) prim_if ();
  acdc_div_if #(.W(`ACDC_BCLK_W)) sec_if ();
  acdc_div_if #(.W(`ACDC_ANA_W))  ana_if ();

  // primary bit clock divider, zero code means 512
  acdc_ratio_div #(
    .W          (`ACDC_BCLK_W),
    .ZERO_RATIO (`ACDC_BCLK_ZERO)
  ) u_prim_div (
    .sys_clk (sys_clk),
    .rst_n   (rst_n),
    .link    (prim_if.div)
  ); // RQ2 RQ3

  // secondary bit clock divider, same coding
  acdc_ratio_div #(
    .W          (`ACDC_BCLK_W),
    .ZERO_RATIO (`ACDC_BCLK_ZERO)
  ) u_sec_div (
    .sys_clk (sys_clk),
    .rst_n   (rst_n),
    .link    (sec_if.div)
  ); // RQ2 RQ3

  // analog ratio divider, zero code means 64
  acdc_ratio_div #(
    .W          (`ACDC_ANA_W),
    .ZERO_RATIO (`ACDC_ANA_ZERO)
  ) u_ana_div (
    .sys_clk (sys_clk),
    .rst_n   (rst_n),
    .link    (ana_if.div)
  ); // RQ7

  // divider controls
  assign prim_if.code      = {primary_bitclk_div_top, r_q.prim_low}; // RQ16
  assign sec_if.code       = {secondary_bitclk_div_top, r_q.sec_low}; // RQ16
  assign ana_if.code       = r_q.ana;
  assign prim_if.auto      = auto_detect_on; // RQ4
  assign sec_if.auto       = auto_detect_on; // RQ4
  assign ana_if.auto       = auto_detect_on; // RQ8
  assign prim_if.auto_code = auto_primary_code;
  assign sec_if.auto_code  = auto_secondary_code;
  assign ana_if.auto_code  = auto_analog_code;

  // an off divider parks low and restarts cleanly when switched on
  assign prim_if.on = r_q.port_en[`ACDC_BIT_PBCLK]; // RQ15 RQ17
  assign sec_if.on  = r_q.port_en[`ACDC_BIT_SBCLK]; // RQ15 RQ17
  // the analog ratio runs whenever either of its n or m stages is on
  assign ana_if.on  = r_q.core_en[`ACDC_BIT_N] | r_q.core_en[`ACDC_BIT_M]; // RQ17

  // address decode
  assign hit_prim = (reg_addr == `ACDC_ADDR_PRIM_LOW);
  assign hit_sec  = (reg_addr == `ACDC_ADDR_SEC_LOW);
  assign hit_ana  = (reg_addr == `ACDC_ADDR_ANA);
  assign hit_core = (reg_addr == `ACDC_ADDR_CORE_EN);
  assign hit_port = (reg_addr == `ACDC_ADDR_PORT_EN);

  // read view; reserved bits and unmapped offsets read zero
  always_comb
  begin
    read_word = `ACDC_READ_ZERO;
    if (hit_prim)
      read_word = r_q.prim_low; // RQ1
    else if (hit_sec)
      read_word = r_q.sec_low; // RQ5
    else if (hit_ana)
      read_word = {2'b00, r_q.ana}; // RQ6 RQ9
    else if (hit_core)
      read_word = {5'b00000, r_q.core_en}; // RQ13 RQ9
    else if (hit_port)
      read_word = r_q.port_en; // RQ14
    else
      read_word = `ACDC_READ_ZERO;
  end

  always_comb
  begin
    r_d        = r_q;
    r_d.rvalid = 1'b0;
    if (reg_rd)
    begin
      r_d.rdata  = read_word;
      r_d.rvalid = 1'b1;
    end
    // writes to reserved bits are dropped, so they always hold zero
    if (reg_wr)
    begin
      if (hit_prim)
        r_d.prim_low = reg_wdata; // RQ1
      else if (hit_sec)
        r_d.sec_low = reg_wdata; // RQ5
      else if (hit_ana)
        r_d.ana = reg_wdata[`ACDC_ANA_W-1:0]; // RQ6 RQ9
      else if (hit_core)
        r_d.core_en = reg_wdata[`ACDC_CORE_W-1:0]; // RQ13 RQ9
      else if (hit_port)
        r_d.port_en = reg_wdata; // RQ14
      else
        r_d.rvalid = r_d.rvalid;
    end
  end

  always_ff @(posedge sys_clk or negedge rst_n)
  begin
    if (!rst_n)
    begin
      r_q.prim_low <= `ACDC_RST_PRIM_LOW; // RQ1
      r_q.sec_low  <= `ACDC_RST_SEC_LOW; // RQ5
      r_q.ana      <= `ACDC_RST_ANA; // RQ6
      r_q.core_en  <= `ACDC_RST_CORE_EN; // RQ13
      r_q.port_en  <= `ACDC_RST_PORT_EN; // RQ14
      r_q.rdata    <= `ACDC_RST_RDATA;
      r_q.rvalid   <= 1'b0;
    end
    else
      r_q <= r_d;
  end

  // outputs, all from flops
  assign reg_rdata              = r_q.rdata;
  assign reg_rvalid             = r_q.rvalid;
  assign primary_bitclk_out     = prim_if.clk_lvl;
  assign primary_bitclk_tick    = prim_if.tick;
  assign secondary_bitclk_out   = sec_if.clk_lvl;
  assign secondary_bitclk_tick  = sec_if.tick;
  assign analog_ratio_clk       = ana_if.clk_lvl;
  assign analog_ratio_tick      = ana_if.tick;
  assign n_divider_on           = r_q.core_en[`ACDC_BIT_N]; // RQ10
  assign m_divider_on           = r_q.core_en[`ACDC_BIT_M]; // RQ11
  assign density_mod_divider_on = r_q.core_en[`ACDC_BIT_PDM]; // RQ12
  assign adc_element_match_div_on = r_q.port_en[`ACDC_BIT_ADC_DEM]; // RQ15
  assign adc_modulator_div_on   = r_q.port_en[`ACDC_BIT_ADC_MOD]; // RQ15
  assign dac_element_match_div_on = r_q.port_en[`ACDC_BIT_DAC_DEM]; // RQ15
  assign dac_modulator_div_on   = r_q.port_en[`ACDC_BIT_DAC_MOD]; // RQ15
  assign primary_bitclk_div_on  = r_q.port_en[`ACDC_BIT_PBCLK]; // RQ15
  assign secondary_bitclk_div_on = r_q.port_en[`ACDC_BIT_SBCLK]; // RQ15
  assign primary_frame_div_on   = r_q.port_en[`ACDC_BIT_PFRAME]; // RQ15
  assign secondary_frame_div_on = r_q.port_en[`ACDC_BIT_SFRAME]; // RQ15

endmodule

// ==== sim/acdc_assertions.sv ====
// concurrent checks on the divider configuration ports
`timescale 1ns/10ps
module acdc_assertions (
  input wire logic       sys_clk,
  input wire logic       rst_b,
  input wire logic       reg_wr,
  input wire logic       reg_rd,
  input wire logic [7:0] reg_addr,
  input wire logic [7:0] reg_wdata,
  input wire logic [7:0] reg_rdata,
  input wire logic       reg_rvalid,
  input wire logic       primary_bitclk_out,
  input wire logic       primary_bitclk_tick,
  input wire logic       primary_bitclk_div_on,
  input wire logic       secondary_frame_div_on,
  input wire logic       adc_element_match_div_on,
  input wire logic       analog_ratio_clk,
  input wire logic       n_divider_on,
  input wire logic       m_divider_on,
  input wire logic       density_mod_divider_on
);
  default clocking @(posedge sys_clk); endclocking
  default disable iff (!rst_b);
  a_read_answer: assert property (reg_rd |=> reg_rvalid)
    else $error("read not answered");
  a_no_stray_valid: assert property (!reg_rd |=> !reg_rvalid)
    else $error("valid without read");
  a_ana_res_zero: assert property (reg_rd && reg_addr == 8'h3e |=> reg_rdata[7:6] == 2'h0)
    else $error("reserved ratio bits not zero");
  a_core_res_zero: assert property (reg_rd && reg_addr == 8'h44 |=> reg_rdata[7:3] == 5'h00)
    else $error("reserved enable bits not zero");
  a_core_en_wr: assert property (reg_wr && reg_addr == 8'h44 |=>
    {n_divider_on, m_divider_on, density_mod_divider_on} == $past(reg_wdata[2:0]))
    else $error("core enables not written");
  a_port_en_wr: assert property (reg_wr && reg_addr == 8'h45 |=>
    {adc_element_match_div_on, primary_bitclk_div_on, secondary_frame_div_on}
    == {$past(reg_wdata[7]), $past(reg_wdata[3]), $past(reg_wdata[0])})
    else $error("port enables not written");
  a_tick_on_rise: assert property (primary_bitclk_tick |-> primary_bitclk_out)
    else $error("tick with low bit clock");
  a_first_period: assert property ($rose(primary_bitclk_div_on) |=> primary_bitclk_tick)
    else $error("enabled divider did not start");
  a_bclk_off_low: assert property (!primary_bitclk_div_on [*2] |->
    !primary_bitclk_out && !primary_bitclk_tick)
    else $error("disabled bit clock active");
  a_ana_off_low: assert property (!(n_divider_on || m_divider_on) [*2] |->
    !analog_ratio_clk)
    else $error("disabled ratio clock active");
endmodule

// ==== sim/tb.sv ====
// self-checking bench for the divider configuration block
`timescale 1ns/10ps
module tb;
  logic       sys_clk, rst_b, reg_wr, reg_rd, auto_detect_on;
  logic [7:0] reg_addr, reg_wdata, reg_rdata;
  logic       reg_rvalid, primary_bitclk_div_top, secondary_bitclk_div_top;
  logic [8:0] auto_primary_code, auto_secondary_code;
  logic [5:0] auto_analog_code;
  logic       primary_bitclk_out, primary_bitclk_tick, secondary_bitclk_out;
  logic       secondary_bitclk_tick, analog_ratio_clk, analog_ratio_tick;
  logic       n_divider_on, m_divider_on, density_mod_divider_on;
  logic       adc_element_match_div_on, adc_modulator_div_on, dac_element_match_div_on;
  logic       dac_modulator_div_on, primary_bitclk_div_on, secondary_bitclk_div_on;
  logic       primary_frame_div_on, secondary_frame_div_on;
  logic [7:0] ra [5] = '{8'h3c, 8'h3d, 8'h3e, 8'h44, 8'h45};
  logic [7:0] rv [5] = '{8'h01, 8'h01, 8'h01, 8'h00, 8'h00};
  int         n_fail;
  int         check_count;

  acdc_clock_divider_config i_dut (.sys_clk, .rst_b, .reg_wr, .reg_rd, .reg_addr,
    .reg_wdata, .reg_rdata, .reg_rvalid, .auto_detect_on, .primary_bitclk_div_top,
    .secondary_bitclk_div_top, .auto_primary_code, .auto_secondary_code,
    .auto_analog_code, .primary_bitclk_out, .primary_bitclk_tick, .secondary_bitclk_out,
    .secondary_bitclk_tick, .analog_ratio_clk, .analog_ratio_tick, .n_divider_on,
    .m_divider_on, .density_mod_divider_on, .adc_element_match_div_on,
    .adc_modulator_div_on, .dac_element_match_div_on, .dac_modulator_div_on,
    .primary_bitclk_div_on, .secondary_bitclk_div_on, .primary_frame_div_on,
    .secondary_frame_div_on);

  initial
  begin
    sys_clk = 1'b0;
    forever #4 sys_clk = ~sys_clk;
  end

  task automatic conclude();
    if (n_fail == 0 && check_count > 0)
      $display("Testbench passed");
    else
      $display("Testbench failed");
    $finish;
  endtask

  task automatic chk(input logic [15:0] got, input logic [15:0] exp);
    check_count++;
    if (got !== exp)
    begin
      n_fail++;
      $display("[ERR] t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask

  // trailing idle cycle keeps the strobe from being raised in the step it drops
  task automatic wr(input logic [7:0] a, input logic [7:0] d);
    reg_addr = a;
    reg_wdata = d;
    reg_wr = 1'b1;
    @(negedge sys_clk);
    reg_wr = 1'b0;
    @(negedge sys_clk);
  endtask

  task automatic rd(input logic [7:0] a, input logic [7:0] e);
    int n;
    reg_addr = a;
    reg_rd = 1'b1;
    @(negedge sys_clk);
    reg_rd = 1'b0;
    n = 0;
    while (reg_rvalid !== 1'b1 && n < 4)
    begin
      @(negedge sys_clk);
      n++;
    end
    chk({reg_rvalid, reg_rdata}, {1'b1, e});
    if (n == 4)
      conclude();
    @(negedge sys_clk);
  endtask

  function automatic logic tk(input int s);
    case (s)
      0: return primary_bitclk_tick;
      1: return secondary_bitclk_tick;
      default: return analog_ratio_tick;
    endcase
  endfunction

  task automatic gap(input int s, output int n);
    n = 0;
    do
    begin
      @(negedge sys_clk);
      n++;
    end
    while (tk(s) !== 1'b1 && n < 1100);
    if (n >= 1100)
    begin
      n_fail++;
      conclude();
    end
  endtask

  // new codes only land at a period end, so the first two gaps are discarded
  task automatic run(input int s, input logic [7:0] a, input logic [7:0] d,
                     input logic au, input int e);
    int n;
    wr(a, d);
    auto_detect_on = au;
    repeat (3) gap(s, n);
    chk(n[15:0], e[15:0]);
  endtask

  initial
  begin
    n_fail = 0;
    check_count = 0;
    rst_b = 1'b0;
    reg_wr = 1'b0;
    reg_rd = 1'b0;
    reg_addr = 8'h00;
    reg_wdata = 8'h00;
    auto_detect_on = 1'b0;
    primary_bitclk_div_top = 1'b0;
    secondary_bitclk_div_top = 1'b0;
    auto_primary_code = 9'h005;
    auto_secondary_code = 9'h006;
    auto_analog_code = 6'h07;
    repeat (4) @(negedge sys_clk);
    rst_b = 1'b1;
    repeat (3) @(negedge sys_clk);
    foreach (ra[i]) rd(ra[i], rv[i]);
    wr(8'h3e, 8'h3f);
    rd(8'h3e, 8'h3f);
    wr(8'h44, 8'h07);
    rd(8'h44, 8'h07);
    chk({n_divider_on, m_divider_on, density_mod_divider_on}, 3'h7);
    // single pattern catches m swapped with n or with the modulation bit; n keeps the analog ratio running
    wr(8'h44, 8'h05);
    chk({n_divider_on, m_divider_on, density_mod_divider_on}, 3'h5);
    wr(8'h3d, 8'ha5);
    rd(8'h3d, 8'ha5);
    wr(8'h50, 8'hff);
    rd(8'h50, 8'h00);
    for (int i = 0; i < 8; i++)
    begin
      wr(8'h45, 8'h01 << i);
      chk({adc_element_match_div_on, adc_modulator_div_on, dac_element_match_div_on,
        dac_modulator_div_on, primary_bitclk_div_on, secondary_bitclk_div_on,
        primary_frame_div_on, secondary_frame_div_on}, 8'h01 << i);
    end
    wr(8'h45, 8'h0c);
    run(0, 8'h3c, 8'h00, 1'b0, 512);
    run(0, 8'h3c, 8'h01, 1'b0, 1);
    run(0, 8'h3c, 8'h03, 1'b0, 3);
    primary_bitclk_div_top = 1'b1;
    run(0, 8'h3c, 8'hff, 1'b0, 511);
    primary_bitclk_div_top = 1'b0;
    run(0, 8'h3c, 8'h03, 1'b1, 5);
    run(1, 8'h3d, 8'h00, 1'b0, 512);
    run(1, 8'h3d, 8'h02, 1'b0, 2);
    run(2, 8'h3e, 8'h00, 1'b0, 64);
    run(2, 8'h3e, 8'h3f, 1'b0, 63);
    run(2, 8'h3e, 8'h3f, 1'b1, 7);
    wr(8'h45, 8'h00);
    repeat (2) @(negedge sys_clk);
    chk({primary_bitclk_out, secondary_bitclk_out}, 2'h0);
    conclude();
  end
endmodule

bind acdc_clock_divider_config acdc_assertions i_chk (.sys_clk, .rst_b, .reg_wr, .reg_rd,
  .reg_addr, .reg_wdata, .reg_rdata, .reg_rvalid, .primary_bitclk_out,
  .primary_bitclk_tick, .primary_bitclk_div_on, .secondary_frame_div_on,
  .adc_element_match_div_on, .analog_ratio_clk, .n_divider_on, .m_divider_on,
  .density_mod_divider_on);
